// >>> src/pin_sync.sv
// three-stage synchroniser for pin levels entering the test clock
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sync_s;
  sync_s cur_ff;
  sync_s nxt_cur;

  // stage one feeds only stage two; a bit moves once two and three agree
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.s1 = d_in;
    nxt_cur.s2 = cur_ff.s1;
    nxt_cur.s3 = cur_ff.s2;
    nxt_cur.held = (cur_ff.s2 ^ cur_ff.s3) & cur_ff.held | ~(cur_ff.s2 ^ cur_ff.s3) & cur_ff.s2;
  end

  always_ff @(posedge clk_in)
  begin
    cur_ff <= nxt_cur;
  end

  assign q_out = cur_ff.held;
endmodule : pin_sync

// >>> src/scan_tap_defines.svh
// constants for the memory boundary-scan test port
`ifndef SCAN_TAP_DEFINES_SVH
`define SCAN_TAP_DEFINES_SVH
`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_RFU_A 3'h3
`define IR_SAMPLE_PRE 3'h4
`define IR_PRIVATE 3'h5
`define IR_RFU_B 3'h6
`define IR_BYPASS 3'h7
`define IR_CAPTURE_PAT 2'h1
`define ID_WIDTH 32
`define RESET_TMS_EDGES 5
`define SYNC_STAGES 3
`endif

// >>> src/scan_tap_pkg.sv
// types for the memory boundary-scan test port
package scan_tap_pkg;
  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr,
    st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir,
    st_exit2_ir, st_upd_ir
  } tap_state_e;
  typedef enum logic [1:0] {path_ir, path_bypass, path_id, path_bsr} scan_path_e;
endpackage : scan_tap_pkg

// >>> src/sram_boundary_scan_tap.sv
// boundary-scan test access port of a synchronous burst memory
`timescale 1ns/100ps
`include "scan_tap_defines.svh"
module sram_boundary_scan_tap #(
  parameter int BSR_LEN = 16,
  parameter int PIN_COUNT = 12,
  parameter logic [BSR_LEN-1:0] PIN_CELL_MASK = 16'h0fff,
  parameter logic [`ID_WIDTH-1:0] ID_CODE = 32'h0000_5a5b, // arbitrary value
  parameter logic [`ID_WIDTH-1:0] POR_CYCLES = 32'h0000_0004
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tms_drive_in,
  input wire logic tdi_in,
  input wire logic tdi_drive_in,
  input wire logic [PIN_COUNT-1:0] pins_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic mem_out_hiz_out,
  output logic [1:0] selected_path_out
);
  import scan_tap_pkg::*;

  // power-up request on the memory clock; srst models power-on
  typedef struct packed {
    logic req;
  } sys_s;
  sys_s sys_ff;
  sys_s nxt_sys;

  typedef struct packed {
    logic [`IR_WIDTH-1:0] ir_shift;
    logic [`IR_WIDTH-1:0] ir_held;
    logic bypass;
    logic [`ID_WIDTH-1:0] id_shift;
    logic [BSR_LEN-1:0] bsr;
    logic hiz;
  } tap_s;

  localparam tap_s TAP_RESET = '{
    ir_shift: '0,
    ir_held: `IR_IDCODE,
    bypass: 1'b0,
    id_shift: '0,
    bsr: '1,
    hiz: 1'b0
  };
  tap_s tap_ff;
  tap_s nxt_tap;

  typedef struct packed {
    logic tdo;
    logic oe;
  } neg_s;
  neg_s neg_ff;
  neg_s nxt_neg;

  tap_state_e state;
  logic tms_eff;
  logic tdi_eff;
  logic por_tck;
  logic por_ack;
  logic [1:0] back_sync;
  logic [PIN_COUNT-1:0] pins_sync;
  logic [BSR_LEN-1:0] capture_vec;
  scan_path_e path;
  logic serial_bit;

  function automatic scan_path_e path_of(input logic [`IR_WIDTH-1:0] ir);
    unique case (ir)
      `IR_EXTEST, `IR_SAMPLE_Z, `IR_SAMPLE_PRE: path_of = path_bsr;
      `IR_IDCODE: path_of = path_id;
      default: path_of = path_bypass; // rfu and private act as bypass
    endcase
  endfunction : path_of

  // states in which the instruction register sits in the serial path
  function automatic logic in_ir_column(input tap_state_e s);
    unique case (s)
      st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir: in_ir_column = 1'b1;
      default: in_ir_column = 1'b0;
    endcase
  endfunction : in_ir_column

  function automatic logic drives_tdo(input tap_state_e s);
    drives_tdo = (s == st_shift_ir) || (s == st_shift_dr);
  endfunction : drives_tdo

  // undriven pins float to the internal pull-up level
  assign tms_eff = tms_drive_in ? tms_in : 1'b1;
  assign tdi_eff = tdi_drive_in ? tdi_in : 1'b1;

  // request dropped once the test side echoes it; a stale echo is harmless,
  // the test side stays in reset until it has seen the drop
  always_comb
  begin
    nxt_sys = sys_ff;
    if (por_ack)
      nxt_sys.req = 1'b0;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      sys_ff <= '{req: 1'b1}; // reset wins over a clearing echo
    else
      sys_ff <= nxt_sys;
  end

  // request held until the test clock runs, so a stopped clock still resets
  pin_sync #(
    .WIDTH(1)
  ) u_por_sync (
    .clk_in(tck_in),
    .d_in(sys_ff.req),
    .q_out(por_tck)
  );

  // reset echo and high-z flag carried back to the memory clock
  pin_sync #(
    .WIDTH(2)
  ) u_back_sync (
    .clk_in(clock_in),
    .d_in({tap_ff.hiz, por_tck}),
    .q_out(back_sync)
  );
  assign por_ack = back_sync[0];

  tap_fsm u_fsm (
    .tck_in(tck_in),
    .por_in(por_tck),
    .tms_in(tms_eff),
    .state_out(state)
  );

  // pins come from the memory clock side, so they cross before capture
  pin_sync #(
    .WIDTH(PIN_COUNT)
  ) u_pin_sync (
    .clk_in(tck_in),
    .d_in(pins_in),
    .q_out(pins_sync)
  );

  // map pins onto the cells flagged in the mask; the rest hold one
  always_comb
  begin
    int p;
    p = 0;
    capture_vec = '1;
    for (int i = 0; i < BSR_LEN; i++)
    begin
      if (PIN_CELL_MASK[i] && p < PIN_COUNT)
      begin
        capture_vec[i] = pins_sync[p];
        p = p + 1;
      end
    end
  end

  // the ir is in the path in ir states, else the held instruction decides
  always_comb
  begin
    if (in_ir_column(state))
      path = path_ir;
    else
      path = path_of(tap_ff.ir_held);
  end

  always_comb
  begin
    unique case (path)
      path_ir: serial_bit = tap_ff.ir_shift[0];
      path_bypass: serial_bit = tap_ff.bypass;
      path_id: serial_bit = tap_ff.id_shift[0];
      path_bsr: serial_bit = tap_ff.bsr[0];
    endcase
  end

  always_comb
  begin
    nxt_tap = tap_ff;
    unique case (state)
      st_reset:
      begin
        nxt_tap.ir_held = `IR_IDCODE;
      end
      st_cap_ir:
      begin
        nxt_tap.ir_shift = {tap_ff.ir_held[`IR_WIDTH-1], `IR_CAPTURE_PAT};
      end
      st_shift_ir:
      begin
        nxt_tap.ir_shift = {tdi_eff, tap_ff.ir_shift[`IR_WIDTH-1:1]};
      end
      st_upd_ir:
      begin
        nxt_tap.ir_held = tap_ff.ir_shift;
      end
      st_cap_dr:
      begin
        unique case (path)
          path_bypass: nxt_tap.bypass = 1'b0;
          path_id: nxt_tap.id_shift = ID_CODE;
          path_bsr: nxt_tap.bsr = capture_vec;
          default: nxt_tap.bypass = tap_ff.bypass;
        endcase
      end
      st_shift_dr:
      begin
        unique case (path)
          path_bypass: nxt_tap.bypass = tdi_eff;
          path_id: nxt_tap.id_shift = {tdi_eff, tap_ff.id_shift[`ID_WIDTH-1:1]};
          path_bsr: nxt_tap.bsr = {tdi_eff, tap_ff.bsr[BSR_LEN-1:1]};
          default: nxt_tap.bypass = tap_ff.bypass;
        endcase
      end
      default:
      begin
        nxt_tap.bypass = tap_ff.bypass;
      end
    endcase
    // registered here so only a single settled bit crosses to the memory clock
    nxt_tap.hiz = (nxt_tap.ir_held == `IR_SAMPLE_Z);
  end

  // sampled on the rising test clock edge
  always_ff @(posedge tck_in)
  begin
    if (por_tck)
      tap_ff <= TAP_RESET;
    else
      tap_ff <= nxt_tap;
  end

  always_comb
  begin
    nxt_neg.tdo = serial_bit;
    nxt_neg.oe = drives_tdo(state);
  end

  // output launched half a cycle later so the far end samples cleanly
  always_ff @(negedge tck_in)
  begin
    if (por_tck)
      neg_ff <= '{tdo: 1'b0, oe: 1'b0};
    else
      neg_ff <= nxt_neg;
  end

  assign tdo_out = neg_ff.tdo;
  assign tdo_oe_out = neg_ff.oe;
  assign mem_out_hiz_out = back_sync[1];
  assign selected_path_out = path;
endmodule : sram_boundary_scan_tap

// >>> src/tap_fsm.sv
// test port controller state machine on the test clock
`timescale 1ns/100ps
module tap_fsm
  import scan_tap_pkg::*;
(
  input wire logic tck_in,
  input wire logic por_in,
  input wire logic tms_in,
  output scan_tap_pkg::tap_state_e state_out
);
  typedef struct packed {
    tap_state_e state;
  } fsm_s;
  fsm_s cur_ff;
  fsm_s nxt_cur;

  // five ones from any state land in reset
  always_comb
  begin
    nxt_cur = cur_ff;
    unique case (cur_ff.state)
      st_reset: nxt_cur.state = tms_in ? st_reset : st_idle;
      st_idle: nxt_cur.state = tms_in ? st_sel_dr : st_idle;
      st_sel_dr: nxt_cur.state = tms_in ? st_sel_ir : st_cap_dr;
      st_cap_dr: nxt_cur.state = tms_in ? st_exit1_dr : st_shift_dr;
      st_shift_dr: nxt_cur.state = tms_in ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: nxt_cur.state = tms_in ? st_upd_dr : st_pause_dr;
      st_pause_dr: nxt_cur.state = tms_in ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: nxt_cur.state = tms_in ? st_upd_dr : st_shift_dr;
      st_upd_dr: nxt_cur.state = tms_in ? st_sel_dr : st_idle;
      st_sel_ir: nxt_cur.state = tms_in ? st_reset : st_cap_ir;
      st_cap_ir: nxt_cur.state = tms_in ? st_exit1_ir : st_shift_ir;
      st_shift_ir: nxt_cur.state = tms_in ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: nxt_cur.state = tms_in ? st_upd_ir : st_pause_ir;
      st_pause_ir: nxt_cur.state = tms_in ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: nxt_cur.state = tms_in ? st_upd_ir : st_shift_ir;
      st_upd_ir: nxt_cur.state = tms_in ? st_sel_dr : st_idle;
    endcase
  end

  always_ff @(posedge tck_in)
  begin
    if (por_in)
      cur_ff <= '{state: st_reset};
    else
      cur_ff <= nxt_cur;
  end

  assign state_out = cur_ff.state;
endmodule : tap_fsm

// >>> tb/scan_host.sv
// far-side scan controller model driving the test port pins
`timescale 1ns/100ps
module scan_host (
  output logic tck_out,
  output logic tms_out,
  output logic tms_drive_out,
  output logic tdi_out,
  output logic tdi_drive_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  logic last_tdo;
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tms_drive_out = 1'b1;
    tdi_out = 1'b1;
    tdi_drive_out = 1'b1;
    last_tdo = 1'b0;
  end
  // one test clock period; the clock stands low between frames
  task step(input logic tms, input logic tms_drv, input logic tdi, input logic tdi_drv,
    output logic tdo);
    tms_out = tms_drv ? tms : ~tms_out; // undriven pin shows junk
    tms_drive_out = tms_drv;
    tdi_out = tdi_drv ? tdi : ~tdi_out;
    tdi_drive_out = tdi_drv;
    #24 tck_out = 1'b1;
    tdo = tdo_oe_in ? tdo_in : ~last_tdo; // released line keeps no old level
    last_tdo = tdo;
    #24 tck_out = 1'b0;
  endtask : step
  task walk(input logic [7:0] seq, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b1, 1'b0, 1'b1, b);
  endtask : walk
  task tlr;
    walk(8'h1f, 5); // five ones reset the controller
  endtask : tlr
  task load_ir(input logic [2:0] code, output logic [2:0] cap);
    walk(8'h06, 5);
    for (int i = 0; i < 3; i++)
      step(i == 2, 1'b1, code[i], 1'b1, cap[i]);
    walk(8'h01, 2);
  endtask : load_ir
  task scan_dr(input int n, input logic [31:0] din, input logic tdi_drv,
    output logic [31:0] dout);
    dout = '0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++)
      step(i == n - 1, 1'b1, din[i], tdi_drv, dout[i]);
    walk(8'h01, 2);
  endtask : scan_dr
endmodule : scan_host

// >>> tb/scan_tap_properties.sv
// concurrent checks on the test port pins
`timescale 1ns/100ps
`include "scan_tap_defines.svh"
module scan_tap_properties #(
  parameter int PIN_COUNT = 12,
  parameter logic [`ID_WIDTH-1:0] ID_CODE = 32'h0000_0001
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tms_drive_in,
  input wire logic tdi_in,
  input wire logic tdi_drive_in,
  input wire logic [PIN_COUNT-1:0] pins_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic mem_out_hiz_out,
  input wire logic [1:0] selected_path_out
);
  logic tms_eff;
  logic tdi_eff;
  logic [2:0] ones_ff = 3'h0;
  logic tdo_rise_ff;
  // floating pins read as one
  assign tms_eff = tms_drive_in ? tms_in : 1'b1;
  assign tdi_eff = tdi_drive_in ? tdi_in : 1'b1;
  always_ff @(posedge tck_in)
  begin
    ones_ff <= (srst_in || !tms_eff) ? 3'h0 : ((ones_ff == 3'h5) ? ones_ff : ones_ff + 3'h1);
    tdo_rise_ff <= tdo_out;
  end
  tms_reset_a: assert property (@(posedge tck_in) disable iff (srst_in)
    ones_ff == 3'h5 |=> selected_path_out == 2'h2 && !tdo_oe_out) else $error("no reset");
  oe_enter_a: assert property (@(posedge tck_in) disable iff (srst_in)
    $rose(tdo_oe_out) |-> !$past(tms_eff)) else $error("oe rose outside shift entry");
  oe_leave_a: assert property (@(posedge tck_in) disable iff (srst_in)
    $fell(tdo_oe_out) |-> $past(tms_eff)) else $error("oe fell outside shift exit");
  oe_hold_a: assert property (@(posedge tck_in) disable iff (srst_in)
    tdo_oe_out && !tms_eff |=> tdo_oe_out) else $error("oe dropped in shift");
  tdo_edge_a: assert property (@(negedge tck_in) disable iff (srst_in)
    tdo_out === tdo_rise_ff) else $error("tdo moved while clock high");
  ir_capture_a: assert property (@(posedge tck_in) disable iff (srst_in)
    $rose(tdo_oe_out) && selected_path_out == 2'h0 |-> tdo_out ##1 (!tdo_out || !tdo_oe_out))
    else $error("ir capture pattern wrong");
  bypass_delay_a: assert property (@(posedge tck_in) disable iff (srst_in)
    selected_path_out == 2'h1 && tdo_oe_out && !tms_eff |=> tdo_out == $past(tdi_eff))
    else $error("bypass delay wrong");
  id_first_a: assert property (@(posedge tck_in) disable iff (srst_in)
    $rose(tdo_oe_out) && selected_path_out == 2'h2 |-> tdo_out == ID_CODE[0])
    else $error("id first bit wrong");
endmodule : scan_tap_properties
bind sram_boundary_scan_tap scan_tap_properties #(.PIN_COUNT(PIN_COUNT), .ID_CODE(ID_CODE))
  u_scan_tap_properties (.clock_in(clock_in), .srst_in(srst_in), .tck_in(tck_in),
  .tms_in(tms_in), .tms_drive_in(tms_drive_in), .tdi_in(tdi_in), .tdi_drive_in(tdi_drive_in),
  .pins_in(pins_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .mem_out_hiz_out(mem_out_hiz_out), .selected_path_out(selected_path_out));

// >>> tb/tb.sv
// self-checking bench for the memory boundary-scan test port
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  localparam logic [31:0] ID_VAL = 32'h0000_3c35; // arbitrary value
  logic clock_in;
  logic srst_in;
  logic tck_in;
  logic tms_in;
  logic tms_drive_in;
  logic tdi_in;
  logic tdi_drive_in;
  logic [11:0] pins_in;
  logic tdo_out;
  logic tdo_oe_out;
  logic mem_out_hiz_out;
  logic [1:0] selected_path_out;
  logic [2:0] held;
  logic [2:0] cap;
  logic [31:0] din;
  logic [31:0] dout;
  logic [31:0] exp_dr;
  logic b;
  int n;
  int num_errors = 0;
  int num_checks = 0;
  sram_boundary_scan_tap #(.ID_CODE(ID_VAL)) u_sram_boundary_scan_tap (.clock_in(clock_in),
    .srst_in(srst_in), .tck_in(tck_in), .tms_in(tms_in), .tms_drive_in(tms_drive_in),
    .tdi_in(tdi_in), .tdi_drive_in(tdi_drive_in), .pins_in(pins_in), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .mem_out_hiz_out(mem_out_hiz_out),
    .selected_path_out(selected_path_out));
  scan_host u_scan_host (.tck_out(tck_in), .tms_out(tms_in), .tms_drive_out(tms_drive_in),
    .tdi_out(tdi_in), .tdi_drive_out(tdi_drive_in), .tdo_in(tdo_out), .tdo_oe_in(tdo_oe_out));
  // bench model of which register an instruction selects
  function automatic logic [1:0] exp_path(input logic [2:0] c);
    case (c)
      3'h0, 3'h2, 3'h4: exp_path = 2'h3;
      3'h1: exp_path = 2'h2;
      default: exp_path = 2'h1; // private code behaves as bypass here
    endcase
  endfunction : exp_path
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial
  begin
    srst_in = 1'b1;
    pins_in = 12'h000;
    void'($urandom(32'h1b9b));
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    u_scan_host.tlr();
    u_scan_host.tlr();
    // margin: the power-up request needs several test clocks to clear
    u_scan_host.tlr();
    held = 3'h1;
    `CHK(selected_path_out, 2'h2)
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clock_in);
      pins_in <= 12'($urandom);
      u_scan_host.load_ir(3'(c), cap);
      `CHK(cap, {held[2], 2'h1})
      held = 3'(c);
      repeat (6) @(posedge clock_in);
      `CHK(selected_path_out, exp_path(held))
      `CHK(mem_out_hiz_out, held == 3'h2)
      din = $urandom;
      n = (exp_path(held) == 2'h2) ? 32 : ((exp_path(held) == 2'h3) ? 16 : 8);
      u_scan_host.scan_dr(n, din, c != 3, dout);
      case (exp_path(held))
        2'h2: exp_dr = ID_VAL;
        2'h3: exp_dr = {16'h0, 4'hf, pins_in};
        default: exp_dr = {24'h0, (c == 3) ? 7'h7f : din[6:0], 1'b0};
      endcase
      `CHK(dout, exp_dr)
    end
    repeat (5) u_scan_host.step(1'b0, 1'b0, 1'b0, 1'b1, b);
    u_scan_host.walk(8'h00, 1);
    `CHK(selected_path_out, 2'h2)
    end_sim();
  end
endmodule : tb
